// File: verilog/bdr_defines.svh
// Purpose: Constants of the banked data RAM and system register window
// Assumes: Byte-wide core data path, 8-bit direct offsets
// Notes:   Offsets are in-bank direct addresses of the core
// Notes on behaviour
// - Data RAM is 512 bytes in three banks, bank 1 at 100H-1FFH, bank 2 at 200H-27FH.
// - In bank 0, 000H-07FH is RAM and 080H-0FFH is the system register set.
// - Direct accesses use the bank selector value 0, 1 or 2 as the bank.
// - Interrupt entry saves the bank selector and leaves the active bank as it is.
// - The interrupt return instruction reloads the bank selector from the saved copy.
// - Bank-zero instruction forms always reach bank 0 whatever the selector holds.
// - Locations 190H and 191H are reachable only through the two indirect ports.
// - The first indirect port accesses the RAM byte at the high/low pair address.
// - The second indirect port accesses the RAM byte at the Y/Z pair address.
// - R takes the upper byte of a ROM lookup and X is a working ROM address register.
// - The system area holds a stack pointer and eight stack entries of low and high byte.
`ifndef BDR_DEFINES_SVH
`define BDR_DEFINES_SVH

// ****************************************************************
// Memory layout
// ****************************************************************
`define BDR_RAM_DEPTH  512
`define BDR_BANK1_BASE 9'h080
`define BDR_BANK2_BASE 9'h180
`define BDR_HIDE_PAIR  7'h48

// ****************************************************************
// System register offsets in bank 0
// ****************************************************************
`define BDR_OFF_L      8'h80
`define BDR_OFF_H      8'h81
`define BDR_OFF_R      8'h82
`define BDR_OFF_Z      8'h83
`define BDR_OFF_Y      8'h84
`define BDR_OFF_X      8'h85
`define BDR_OFF_FLAGS  8'h86
`define BDR_OFF_BANK   8'h87
`define BDR_OFF_IND1   8'h90
`define BDR_OFF_IND2   8'h91
`define BDR_OFF_PCL    8'h93
`define BDR_OFF_PCH    8'h94
`define BDR_OFF_STACK_POINTER   8'hef
`define BDR_IDX_L      4'h0
`define BDR_IDX_H      4'h1
`define BDR_IDX_R      4'h2
`define BDR_IDX_Z      4'h3
`define BDR_IDX_Y      4'h4
`define BDR_IDX_X      4'h5
`define BDR_IDX_FLAGS  4'h6
`define BDR_IDX_BANK   4'h7

// ****************************************************************
// Field masks and reset value
// ****************************************************************
`define BDR_BANK_MASK  8'h03
`define BDR_FLAGS_MASK 8'hf7
`define BDR_PCH_MASK   8'h1f
`define BDR_RST_BYTE   8'h00

`endif

// File: verilog/bdr_pkg.sv
// Purpose: Types of the banked data RAM block
// Assumes: Used through bdr_pkg:: only
// Notes:   Holds the state record and carriers
package bdr_pkg;

  typedef enum logic [1:0] {
    BDR_IDLE,
    BDR_ACC,
    BDR_RESP
  } bdr_st_t;

  // Decoded bus request
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       be0;
    logic [9:0] idx;
    logic [7:0] wdata;
  } bdr_req_t;

  // Resolved RAM location
  typedef struct packed {
    logic       ok;
    logic [8:0] phys;
  } bdr_loc_t;

  // Whole block state except the RAM array
  typedef struct packed {
    bdr_st_t          st;
    logic             waitr;
    logic [7:0]       rdata;
    logic [15:0][7:0] wk;
    logic [15:0][7:0] stk;
    logic [7:0]       program_counter_low;
    logic [7:0]       program_counter_high;
    logic [7:0]       stack_pointer;
    logic [1:0]       saved;
  } bdr_state_t;

endpackage

// File: verilog/bdr_top.sv
// Purpose: Banked 512-byte data RAM with system register window
// Assumes: Avalon-MM slave, byte register per aligned word
// Notes:   Interrupt entry, return and ROM lookup are core pins
`timescale 1ns/1ps
`default_nettype none
`include "bdr_defines.svh"

module bdr_top (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // Avalon-MM slave
  input  wire logic [11:0] avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [3:0]  avs_byteenable_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Core events
  input  wire logic        irq_entry_i,
  input  wire logic        interrupt_return_instruction_i,
  input  wire logic        rom_load_i,
  input  wire logic [7:0]  rom_hi_i,
  // Core views
  output logic      [1:0]  bank_o,
  output logic      [15:0] yz_o,
  output logic      [7:0]  x_o,
  output logic      [7:0]  r_o
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [7:0]           mem [`BDR_RAM_DEPTH];
  bdr_pkg::bdr_state_t  s_r;
  bdr_pkg::bdr_state_t  s_nxt;
  bdr_pkg::bdr_req_t    req;
  bdr_pkg::bdr_loc_t    dloc;
  bdr_pkg::bdr_loc_t    iloc;
  logic [1:0]           eff_bank;
  logic [7:0]           off;
  logic                 acc;
  logic                 mapped;
  logic                 sys_hit;
  logic                 hidden;
  logic                 ind;
  logic [15:0]          lin;
  logic                 tgt_ok;
  logic [8:0]           tgt_phys;
  logic [7:0]           ram_rd;
  logic [7:0]           sys_rd;
  logic                 ram_we;

  // Bank and offset to RAM location
  function automatic bdr_pkg::bdr_loc_t map_loc(
    input logic [1:0] bk,
    input logic [7:0] of
  );
    bdr_pkg::bdr_loc_t r;
    r.ok   = 1'b0;
    r.phys = 9'h000;
    case (bk)
      2'h0: begin
        r.ok   = ~of[7];
        r.phys = {2'h0, of[6:0]};
      end
      2'h1: begin
        r.ok   = 1'b1;
        r.phys = `BDR_BANK1_BASE + {1'b0, of};
      end
      2'h2: begin
        r.ok   = ~of[7];
        r.phys = `BDR_BANK2_BASE + {2'h0, of[6:0]};
      end
      default: begin
        r.ok   = 1'b0;
      end
    endcase
    return r;
  endfunction

  // ****************************************************************
  // Request decode
  // ****************************************************************
  always_comb begin
    req.rd    = avs_read_i;
    req.wr    = avs_write_i;
    req.be0   = avs_byteenable_i[0];
    req.idx   = avs_address_i[11:2];
    req.wdata = avs_writedata_i[7:0];
  end

  // Address steering
  always_comb begin
    acc      = (s_r.st == bdr_pkg::BDR_ACC);
    mapped   = ~req.idx[9];
    off      = req.idx[7:0];
    // Bank-zero forms bypass the selector
    eff_bank = req.idx[8] ? 2'h0 : s_r.wk[`BDR_IDX_BANK][1:0];
    dloc     = map_loc(eff_bank, off);
    sys_hit  = (eff_bank == 2'h0) && off[7];
    hidden   = (eff_bank == 2'h1) && (off[7:1] == `BDR_HIDE_PAIR);
    ind      = sys_hit && ((off == `BDR_OFF_IND1) || (off == `BDR_OFF_IND2));
    // Pointer pair chosen by port
    lin      = (off == `BDR_OFF_IND1) ?
               {s_r.wk[`BDR_IDX_H], s_r.wk[`BDR_IDX_L]} :
               {s_r.wk[`BDR_IDX_Y], s_r.wk[`BDR_IDX_Z]};
    iloc     = map_loc(lin[9:8], lin[7:0]);
    tgt_ok   = ind ? (iloc.ok && (lin[15:10] == 6'h00))
                   : (dloc.ok && ~hidden);
    tgt_phys = ind ? iloc.phys : dloc.phys;
    ram_rd   = mem[tgt_phys];
  end

  // System register read mux
  always_comb begin
    sys_rd = `BDR_RST_BYTE;
    if (off[7:4] == 4'h8) begin
      sys_rd = s_r.wk[off[3:0]];
    end else if (off[7:4] == 4'hf) begin
      sys_rd = s_r.stk[off[3:0]];
    end else begin
      case (off)
        `BDR_OFF_PCL:  sys_rd = s_r.program_counter_low;
        `BDR_OFF_PCH:  sys_rd = s_r.program_counter_high;
        `BDR_OFF_STACK_POINTER: sys_rd = s_r.stack_pointer;
        default:       sys_rd = `BDR_RST_BYTE;
      endcase
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_nxt  = s_r;
    ram_we = 1'b0;
    case (s_r.st)
      bdr_pkg::BDR_IDLE: begin
        if (req.rd || req.wr) begin
          s_nxt.st = bdr_pkg::BDR_ACC;
        end
      end
      bdr_pkg::BDR_ACC: begin
        s_nxt.st    = bdr_pkg::BDR_RESP;
        s_nxt.waitr = 1'b0;
        s_nxt.rdata = `BDR_RST_BYTE;
        if (mapped && req.wr && req.be0) begin
          if (tgt_ok) begin
            ram_we = 1'b1;
          end else if (sys_hit && ~ind) begin
            if (off[7:4] == 4'h8) begin
              s_nxt.wk[off[3:0]] = req.wdata;
              if (off == `BDR_OFF_BANK) begin
                s_nxt.wk[off[3:0]] = req.wdata & `BDR_BANK_MASK;
              end
              if (off == `BDR_OFF_FLAGS) begin
                s_nxt.wk[off[3:0]] = req.wdata & `BDR_FLAGS_MASK;
              end
            end else if (off[7:4] == 4'hf) begin
              s_nxt.stk[off[3:0]] = req.wdata;
            end else begin
              case (off)
                `BDR_OFF_PCL:  s_nxt.program_counter_low  = req.wdata;
                `BDR_OFF_PCH:  s_nxt.program_counter_high  = req.wdata & `BDR_PCH_MASK;
                `BDR_OFF_STACK_POINTER: s_nxt.stack_pointer = req.wdata;
                default:       s_nxt.program_counter_low  = s_r.program_counter_low;
              endcase
            end
          end
        end else if (mapped && req.rd) begin
          if (tgt_ok) begin
            s_nxt.rdata = ram_rd;
          end else if (sys_hit && ~ind) begin
            s_nxt.rdata = sys_rd;
          end
        end
      end
      bdr_pkg::BDR_RESP: begin
        s_nxt.st    = bdr_pkg::BDR_IDLE;
        s_nxt.waitr = 1'b1;
      end
      default: begin
        s_nxt.st    = bdr_pkg::BDR_IDLE;
        s_nxt.waitr = 1'b1;
      end
    endcase
    // ROM lookup upper byte lands in R
    if (rom_load_i) begin
      s_nxt.wk[`BDR_IDX_R] = rom_hi_i;
    end
    // Entry keeps a copy, active bank untouched
    if (irq_entry_i) begin
      s_nxt.saved = s_r.wk[`BDR_IDX_BANK][1:0];
    end
    // Return restores the copy, wins over a bus write
    if (interrupt_return_instruction_i) begin
      s_nxt.wk[`BDR_IDX_BANK] = {6'h00, s_r.saved};
    end
  end

  // State register
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      s_r       <= '0;
      s_r.waitr <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // RAM array write port
  always_ff @(posedge clock_i) begin
    if (ram_we) begin
      mem[tgt_phys] <= req.wdata;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_comb begin
    avs_readdata_o    = {24'h000000, s_r.rdata};
    avs_waitrequest_o = s_r.waitr;
    bank_o            = s_r.wk[`BDR_IDX_BANK][1:0];
    yz_o              = {s_r.wk[`BDR_IDX_Y], s_r.wk[`BDR_IDX_Z]};
    x_o               = s_r.wk[`BDR_IDX_X];
    r_o               = s_r.wk[`BDR_IDX_R];
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  // Answer two edges after the request is seen
  bus_answer_a: assert property (
    (s_r.st == bdr_pkg::BDR_IDLE && (req.rd || req.wr))
      |-> avs_waitrequest_o [*2] ##1 !avs_waitrequest_o)
    else $error("answer timing wrong");

  bank2_top_a: assert property (
    (acc && !ind && eff_bank == 2'h2 && off[7]) |-> !ram_we)
    else $error("bank 2 upper half written");

  sys_window_a: assert property (
    (acc && sys_hit && !ind) |-> !ram_we)
    else $error("system window hit RAM");

  bank_steer_a: assert property (
    (acc && !req.idx[8]) |-> eff_bank == bank_o)
    else $error("direct bank not from selector");

  save_bank_a: assert property (
    (irq_entry_i && !interrupt_return_instruction_i && !acc) |=> s_r.saved == $past(bank_o)
      && bank_o == $past(bank_o))
    else $error("bank not saved on entry");

  restore_bank_a: assert property (
    interrupt_return_instruction_i |=> bank_o == $past(s_r.saved))
    else $error("bank not restored on return");

  bank_zero_a: assert property (
    (acc && req.idx[8] && !off[7])
      |-> tgt_ok && tgt_phys == {1'b0, off})
    else $error("bank-zero form misrouted");

  hidden_pair_a: assert property (
    (acc && hidden && !ind) |-> !ram_we)
    else $error("hidden pair reached directly");

  hl_port_a: assert property (
    (acc && sys_hit && off == `BDR_OFF_IND1)
      |-> lin == {s_r.wk[`BDR_IDX_H], s_r.wk[`BDR_IDX_L]})
    else $error("first port not on pair");

  yz_port_a: assert property (
    (acc && sys_hit && off == `BDR_OFF_IND2) |-> lin == yz_o)
    else $error("second port not on pair");

  rom_high_a: assert property (
    (rom_load_i && !interrupt_return_instruction_i) |=> r_o == $past(rom_hi_i))
    else $error("lookup byte not in R");

  stack_read_a: assert property (
    (acc && mapped && req.rd && !req.wr && sys_hit
      && off == `BDR_OFF_STACK_POINTER)
      |=> avs_readdata_o[7:0] == $past(s_r.stack_pointer))
    else $error("stack pointer read wrong");

  bank_three_a: assert property (
    (acc && !ind && eff_bank == 2'h3) |-> !ram_we)
    else $error("reserved bank wrote RAM");

endmodule
`default_nettype wire

// File: bench/bdr_core_model.sv
// Purpose: Core-side event source for the data RAM block
// Assumes: fire is called just after a rising clock edge
// Notes:   One-cycle pulses; ROM byte goes stale when idle
`timescale 1ns/1ps
`default_nettype none
module bdr_core_model (
  // Clock
  input  wire logic       clock_i,
  // Core events
  output logic            irq_entry_o,
  output logic            interrupt_return_instruction_o,
  output logic            rom_load_o,
  output logic      [7:0] rom_hi_o
);
  // ****************************************************************
  // Event pulses
  // ****************************************************************
  // Quiet at time zero
  initial begin
    irq_entry_o = 1'b0;
    interrupt_return_instruction_o      = 1'b0;
    rom_load_o  = 1'b0;
    rom_hi_o    = 8'h00;
  end
  // Raise one event for exactly one cycle
  task automatic fire(input int k, input logic [7:0] hi);
    irq_entry_o <= (k == 0);
    interrupt_return_instruction_o      <= (k == 1);
    rom_load_o  <= (k == 2);
    rom_hi_o    <= hi;
    @(posedge clock_i);
    irq_entry_o <= 1'b0;
    interrupt_return_instruction_o      <= 1'b0;
    rom_load_o  <= 1'b0;
    rom_hi_o    <= ~hi; // Stale byte not held
  endtask
endmodule
`default_nettype wire

// File: bench/bdr_top_tb_top.sv
// Purpose: Self-checking bench of the banked data RAM
// Assumes: Avalon answer after a bounded wait
// Notes:   Keyed model: RAM by address, window at 1000H+offset
`timescale 1ns/1ps
`default_nettype none
module bdr_top_tb_top;
  logic        clock_i;
  logic        rst_n_i;
  logic [11:0] avs_address_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [3:0]  avs_byteenable_i;
  logic [31:0] avs_writedata_i;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        irq_entry_i;
  logic        interrupt_return_instruction_i;
  logic        rom_load_i;
  logic [7:0]  rom_hi_i;
  logic [1:0]  bank_o;
  logic [15:0] yz_o;
  logic [7:0]  x_o;
  logic [7:0]  r_o;
  logic [7:0]  m [int];
  logic [7:0]  sv;
  logic [7:0]  l;
  logic [3:0]  be;
  int          compares;
  int          miscompares;
  int          i;
  bdr_top i_bdr_top (.*);
  bdr_core_model i_bdr_core_model (.clock_i(clock_i),
    .irq_entry_o(irq_entry_i), .interrupt_return_instruction_o(interrupt_return_instruction_i),
    .rom_load_o(rom_load_i), .rom_hi_o(rom_hi_i));
  // ****************************************************************
  // Model and helpers
  // ****************************************************************
  function automatic logic [7:0] rn();
    l = {l[6:0], l[7] ^ l[5] ^ l[4] ^ l[3]};
    return l;
  endfunction
  function automatic logic [7:0] gm(int k);
    return m.exists(k) ? m[k] : 8'h00;
  endfunction
  // Word index to model key, -1 when refused
  function automatic int loc(logic [9:0] idx);
    int o, b, p;
    o = idx[7:0];
    b = idx[8] ? 0 : int'(gm('h1087));
    if (idx[9]) return -1;
    if (b == 0 && o >= 'h80) begin
      if (o == 'h90) p = {gm('h1081), gm('h1080)};
      else p = {gm('h1084), gm('h1083)};
      if (o == 'h90 || o == 'h91)
        return (p < 'h80 || (p >= 'h100 && p < 'h280)) ? p : -1;
      if (o < 'h90 || o == 'h93 || o == 'h94 || o >= 'hef)
        return 'h1000 + o;
      return -1;
    end
    if (b == 0) return o;
    if (b == 1) return (o == 'h90 || o == 'h91) ? -1 : 'h100 + o;
    if (b == 2 && o < 'h80) return 'h200 + o;
    return -1;
  endfunction
  function automatic logic [7:0] msk(int k);
    return k == 'h1086 ? 8'hf7 : k == 'h1087 ? 8'h03 :
           k == 'h1094 ? 8'h1f : 8'hff;
  endfunction
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One Avalon transfer, model updated at completion
  task automatic bus(input logic w, input logic [9:0] idx,
                     input logic [7:0] d);
    int n, k;
    logic [7:0] e;
    k = loc(idx);
    e = (k < 0) ? 8'h00 : gm(k);
    avs_address_i <= {idx, 2'b00};
    avs_read_i <= !w;
    avs_write_i <= w;
    avs_byteenable_i <= be;
    avs_writedata_i <= {rn(), rn(), rn(), d};
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 40);
    if (n >= 40) chk("waitrequest", avs_waitrequest_o, 32'h0);
    if (!w) chk("readdata", avs_readdata_o, {24'h0, e});
    if (w && k >= 0 && be[0]) m[k] = d & msk(k);
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clock_i);
  endtask
  // Core event, then selector and R views
  task automatic ev(input int k, input logic [7:0] hi);
    i_bdr_core_model.fire(k, hi);
    if (k == 0) sv = gm('h1087);
    if (k == 1) m['h1087] = sv;
    if (k == 2) m['h1082] = hi;
    @(posedge clock_i);
    chk("bank_o", 32'(bank_o), 32'(gm('h1087)));
    chk("r_o", 32'(r_o), 32'(gm('h1082)));
  endtask
  task automatic finish_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ****************************************************************
  // Clock, watchdog and sequence
  // ****************************************************************
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // Cut a hang short
  initial begin
    repeat (20000) @(posedge clock_i);
    miscompares++;
    finish_test();
  end
  // Main sequence
  initial begin
    {rst_n_i, avs_read_i, avs_write_i, avs_address_i} = '0;
    avs_writedata_i = '0;
    avs_byteenable_i = 4'h1;
    be = 4'h1;
    sv = 8'h00;
    l = 8'h04;
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    chk("views", {bank_o, yz_o, x_o}, 32'h0);
    bus(1'b1, 10'h000, rn());
    for (i = 'h180; i < 'h200; i++) bus(1'b0, i[9:0], 8'h00);
    for (i = 'h180; i < 'h200; i++) bus(1'b1, i[9:0], rn());
    for (i = 'h180; i < 'h200; i++) bus(1'b0, i[9:0], 8'h00);
    chk("yz_o", 32'(yz_o), {gm('h1084), gm('h1083)});
    chk("x_o", 32'(x_o), 32'(gm('h1085)));
    for (i = 0; i < 4; i++) begin
      bus(1'b1, 10'h187, i[7:0]);
      bus(1'b1, 10'h07f, rn());
      bus(1'b1, 10'h0a0, rn());
    end
    for (i = 0; i < 4; i++) begin
      bus(1'b1, 10'h187, i[7:0]);
      chk("bank_o", 32'(bank_o), 32'(i[1:0]));
      bus(1'b0, 10'h07f, 8'h00);
      bus(1'b0, 10'h0a0, 8'h00);
      bus(1'b0, 10'h2a0, 8'h00);
    end
    bus(1'b1, 10'h181, 8'h01);
    bus(1'b1, 10'h180, 8'h90);
    bus(1'b1, 10'h184, 8'h01);
    bus(1'b1, 10'h183, 8'h91);
    bus(1'b1, 10'h190, rn());
    bus(1'b1, 10'h191, rn());
    bus(1'b1, 10'h187, 8'h01);
    bus(1'b1, 10'h090, rn());
    bus(1'b0, 10'h090, 8'h00);
    bus(1'b1, 10'h183, 8'h90);
    bus(1'b0, 10'h191, 8'h00);
    be = 4'he;
    bus(1'b1, 10'h188, rn());
    be = 4'h1;
    bus(1'b0, 10'h188, 8'h00);
    ev(0, 8'h00);
    bus(1'b1, 10'h187, 8'h02);
    bus(1'b1, 10'h020, rn());
    bus(1'b0, 10'h020, 8'h00);
    ev(1, 8'h00);
    bus(1'b0, 10'h187, 8'h00);
    ev(2, rn());
    bus(1'b0, 10'h182, 8'h00);
    finish_test();
  end
endmodule
`default_nettype wire
